// [include/cks_pkg.sv]
// shared constants, types and lookup for the clock synth control block
package cks_pkg;

  // ---------------------------------------------------------------
  // serial slave constants
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR7  = 7'h69;
  localparam int         NUM_CFG      = 8;
  localparam logic [7:0] BLK_COUNT    = 8'h08;
  localparam logic [6:0] IDX_FSEL     = 7'h04;
  localparam logic [6:0] IDX_CTRL6    = 7'h06;
  localparam int         FSEL_LSB     = 0;
  localparam int         SER_EN_BIT   = 0;
  localparam int         CMD_BYTE_BIT = 7;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [63:0] CFG_DEFAULTS = 64'h00000000_f6ffffff;

  // ---------------------------------------------------------------
  // frequencies in khz
  // ---------------------------------------------------------------
  localparam logic [19:0] KHZ_266 = 20'h411ab;  // 266667
  localparam logic [19:0] KHZ_133 = 20'h208d5;  // 133333
  localparam logic [19:0] KHZ_200 = 20'h30d40;  // 200000
  localparam logic [19:0] KHZ_166 = 20'h28b0b;  // 166667
  localparam logic [19:0] KHZ_333 = 20'h51615;  // 333333
  localparam logic [19:0] KHZ_100 = 20'h186a0;  // 100000
  localparam logic [19:0] KHZ_400 = 20'h61a80;  // 400000
  localparam logic [19:0] KHZ_250 = 20'h3d090;  // 250000
  localparam logic [19:0] KHZ_066 = 20'h1046b;  // 66667
  localparam logic [19:0] KHZ_033 = 20'h08235;  // 33333

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [19:0] processor_clock_out0_khz;
    logic [19:0] processor_clock_out1_khz;
    logic [19:0] src_khz;
    logic [19:0] link_khz;
    logic [19:0] pci_khz;
  } cks_freq_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } cks_smb_in_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } cks_state_type;

  typedef enum logic [3:0] {
    STG_ADDR  = 4'h1,
    STG_CMD   = 4'h2,
    STG_COUNT = 4'h4,
    STG_DATA  = 4'h8
  } cks_stage_type;

  // ---------------------------------------------------------------
  // select code to frequency set
  // ---------------------------------------------------------------
  function automatic cks_freq_type cks_freq_lookup(input logic [3:0] sel);
    cks_freq_type f;
    f.src_khz  = KHZ_100;
    f.pci_khz  = KHZ_033;
    f.link_khz = sel[3] ? KHZ_133 : KHZ_066;
    f.processor_clock_out1_khz = KHZ_200;
    case (sel[2:0])
      3'h0:    f.processor_clock_out0_khz = KHZ_266;
      3'h1:    f.processor_clock_out0_khz = KHZ_133;
      3'h2:    f.processor_clock_out0_khz = KHZ_200;
      3'h3:    f.processor_clock_out0_khz = KHZ_166;
      3'h4:    f.processor_clock_out0_khz = KHZ_333;
      3'h5:    f.processor_clock_out0_khz = KHZ_100;
      3'h6:    f.processor_clock_out0_khz = KHZ_400;
      default: f.processor_clock_out0_khz = KHZ_200;
    endcase
    f.processor_clock_out1_khz = (sel[2:0] == 3'h7) ? KHZ_250 : f.processor_clock_out0_khz;
    return f;
  endfunction

endpackage

// [rtl/cks_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module cks_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [rtl/cks_word_xfer.sv]
// toggle handshake carrying a 4-bit word between clock domains
`timescale 1ns/1ps
`default_nettype none
module cks_word_xfer (
  input  wire logic       src_clk,
  input  wire logic       dst_clk,
  input  wire logic       rst,
  input  wire logic       src_load,
  input  wire logic [3:0] src_data,
  output logic            dst_valid,
  output logic      [3:0] dst_data
);
  // loads must be spaced by a few dst cycles; data holds until next load
  logic       tog_q;
  logic [3:0] hold_q;
  logic       tog_s;
  logic       tog_seen_q;
  logic       arrive;
  logic       valid_q;

  always_ff @(posedge src_clk or posedge rst) begin
    if (rst) begin
      tog_q  <= 1'b0;
      hold_q <= 4'h0;
    end else if (src_load) begin
      tog_q  <= ~tog_q;
      hold_q <= src_data;
    end
  end

  cks_sync2 #(.W(1)) u_tog_sync (
    .clk (dst_clk),
    .rst (rst),
    .d   (tog_q),
    .q   (tog_s)
  );

  assign arrive = tog_s ^ tog_seen_q;
  // valid is registered so it rises together with the word it announces
  assign dst_valid = valid_q;

  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      tog_seen_q <= 1'b0;
      valid_q    <= 1'b0;
      dst_data   <= 4'h0;
    end else begin
      tog_seen_q <= tog_s;
      valid_q    <= arrive;
      if (arrive) begin
        dst_data <= hold_q;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/cks_top.sv]
// strap latch, frequency lookup and two-wire config slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - capture frequency straps when power-good strobe is first sampled low
// - after that capture ignore strobe and strap changes unless in test mode
// - config bytes load defaults at reset; no serial access needed
// - support byte write, byte read, block write and block read
// - block bytes go in ascending index, msb first; stop after any byte
// - answer only to the fixed 7-bit slave address
// - command bit 7 zero means block, one means single byte
// - command bits 6:0 index single bytes; zero for block transfers
// - block write acks address, command, count and every data byte
// - with serial-enable bit set, block write has no count byte
// - block read returns count then data after repeated start
// - byte write acks address, command and the one data byte
// - byte read returns one byte after repeated start and address
// - select code maps to cpu, src, link and pci frequencies
// - after capture the strobe pin is an active-high power-down request
// - software select bits mirror straps with the same mapping
module cks_top (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  link_clk,
  input  wire logic                  cpu_supply_good_strobe,
  input  wire logic [3:0]            host_freq_select_straps,
  input  wire logic                  test_mode,
  input  wire cks_pkg::cks_smb_in_type smb_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  output logic                       straps_latched,
  output logic                       power_down_req,
  output cks_pkg::cks_freq_type      freq
);

  // ---------------------------------------------------------------
  // core domain: strap capture and frequency selection
  // ---------------------------------------------------------------
  logic [5:0] pin_s;
  logic       pwrgd_s;
  logic [3:0] straps_s;
  logic       test_s;
  logic       latched_q;
  logic [3:0] strap_q;
  logic [3:0] sel_q;
  logic       pd_q;
  logic       sw_valid;
  logic [3:0] sw_data;
  logic       cap;
  logic       strap_load;

  cks_sync2 #(.W(6)) u_pin_sync (
    .clk (clock),
    .rst (rst),
    .d   ({~cpu_supply_good_strobe, host_freq_select_straps, test_mode}),
    .q   (pin_s)
  );

  // strobe idles high; inverted so the sync reset value reads as idle
  assign pwrgd_s  = ~pin_s[5];
  assign straps_s = pin_s[4:1];
  assign test_s   = pin_s[0];
  // one-shot: only the first low counts, test mode re-arms it
  assign cap        = ~pwrgd_s & (~latched_q | test_s);
  // send only on change so test mode cannot flood the crossing
  assign strap_load = cap & (~latched_q | (straps_s != strap_q));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latched_q <= 1'b0;
      strap_q   <= 4'h0;
      sel_q     <= 4'h0;
      pd_q      <= 1'b0;
      freq      <= cks_pkg::cks_freq_lookup(4'h0);
    end else begin
      if (cap) begin
        latched_q <= 1'b1;
        strap_q   <= straps_s;
        sel_q     <= straps_s;
      end else if (sw_valid) begin
        sel_q     <= sw_data;
      end
      pd_q <= latched_q & pwrgd_s;
      freq <= cks_pkg::cks_freq_lookup(sel_q);
    end
  end

  assign straps_latched = latched_q;
  assign power_down_req = pd_q;

  // ---------------------------------------------------------------
  // crossings
  // ---------------------------------------------------------------
  logic       strap_valid_l;
  logic [3:0] strap_data_l;
  logic       sw_load_l;
  logic [3:0] sw_word_l;

  cks_word_xfer u_strap_x (
    .src_clk   (clock),
    .dst_clk   (link_clk),
    .rst       (rst),
    .src_load  (strap_load),
    .src_data  (straps_s),
    .dst_valid (strap_valid_l),
    .dst_data  (strap_data_l)
  );

  cks_word_xfer u_sw_x (
    .src_clk   (link_clk),
    .dst_clk   (clock),
    .rst       (rst),
    .src_load  (sw_load_l),
    .src_data  (sw_word_l),
    .dst_valid (sw_valid),
    .dst_data  (sw_data)
  );

  // ---------------------------------------------------------------
  // link domain: line sampling and condition detect
  // ---------------------------------------------------------------
  logic [1:0] line_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_p_q;
  logic       sda_p_q;

  cks_sync2 #(.W(2)) u_line_sync (
    .clk (link_clk),
    .rst (rst),
    .d   ({~smb_in.scl, ~smb_in.sda}),
    .q   (line_s)
  );

  // lines idle high; inverted so reset gives no false edge or stop
  assign scl_s = ~line_s[1];
  assign sda_s = ~line_s[0];

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_p_q;
  wire scl_fall  = ~scl_s & scl_p_q;
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ---------------------------------------------------------------
  // link domain: slave state
  // ---------------------------------------------------------------
  cks_pkg::cks_state_type state_q, state_d;
  cks_pkg::cks_stage_type stage_q, stage_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] tx_q, tx_d;
  logic       oe_q, oe_d;
  logic       blk_q, blk_d;
  logic [6:0] idx_q, idx_d;
  logic       rd_mode_q, rd_mode_d;
  logic       mack_ok_q, mack_ok_d;
  logic       wr_en;
  logic [7:0] cfg_q [cks_pkg::NUM_CFG];

  wire       in_range = (idx_q < 7'(cks_pkg::NUM_CFG));
  wire [7:0] rd_byte  = in_range ? cfg_q[idx_q[2:0]] : 8'h00;
  wire       ser_en   = cfg_q[cks_pkg::IDX_CTRL6[2:0]][cks_pkg::SER_EN_BIT];
  wire       byte_end = (state_q == cks_pkg::ST_RX) & scl_fall &
                        (cnt_q == cks_pkg::BIT_CNT_FULL);
  wire       cmd_blk  = ~sr_q[cks_pkg::CMD_BYTE_BIT];
  wire       addr_hit = (sr_q[7:1] == cks_pkg::SLAVE_ADDR7);
  wire [7:0] first_tx = blk_q ? cks_pkg::BLK_COUNT : rd_byte;

  always_comb begin
    state_d   = state_q;
    stage_d   = stage_q;
    cnt_d     = cnt_q;
    sr_d      = sr_q;
    tx_d      = tx_q;
    oe_d      = oe_q;
    blk_d     = blk_q;
    idx_d     = idx_q;
    rd_mode_d = rd_mode_q;
    mack_ok_d = mack_ok_q;
    wr_en     = 1'b0;
    if (start_det) begin
      state_d   = cks_pkg::ST_RX;
      stage_d   = cks_pkg::STG_ADDR;
      cnt_d     = 4'h0;
      oe_d      = 1'b0;
      rd_mode_d = 1'b0;
    end else if (stop_det) begin
      state_d = cks_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        cks_pkg::ST_RX: begin
          if (scl_rise && cnt_q != cks_pkg::BIT_CNT_FULL) begin
            sr_d  = {sr_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (byte_end) begin
            cnt_d   = 4'h0;
            state_d = cks_pkg::ST_ACK;
            oe_d    = 1'b1;
            case (stage_q)
              cks_pkg::STG_ADDR: begin
                if (!addr_hit) begin
                  state_d = cks_pkg::ST_IDLE;
                  oe_d    = 1'b0;
                end else begin
                  rd_mode_d = sr_q[0];
                  stage_d   = sr_q[0] ? cks_pkg::STG_DATA : cks_pkg::STG_CMD;
                end
              end
              cks_pkg::STG_CMD: begin
                blk_d   = cmd_blk;
                idx_d   = cmd_blk ? 7'h00 : sr_q[6:0];
                stage_d = (cmd_blk && !ser_en) ? cks_pkg::STG_COUNT
                                               : cks_pkg::STG_DATA;
              end
              cks_pkg::STG_COUNT: begin
                stage_d = cks_pkg::STG_DATA;
              end
              default: begin
                wr_en = 1'b1;
                if (blk_q) begin
                  idx_d = idx_q + 7'h01;
                end
              end
            endcase
          end
        end
        cks_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rd_mode_q) begin
              state_d = cks_pkg::ST_TX;
              oe_d    = ~first_tx[7];
              tx_d    = {first_tx[6:0], 1'b0};
              cnt_d   = 4'h1;
            end else begin
              state_d = cks_pkg::ST_RX;
              oe_d    = 1'b0;
            end
          end
        end
        cks_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == cks_pkg::BIT_CNT_FULL) begin
              state_d   = cks_pkg::ST_MACK;
              oe_d      = 1'b0;
              mack_ok_d = 1'b0;
            end else begin
              oe_d  = ~tx_q[7];
              tx_d  = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        cks_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_ok_d = ~sda_s;
          end else if (scl_fall) begin
            if (mack_ok_q) begin
              state_d = cks_pkg::ST_TX;
              oe_d    = ~rd_byte[7];
              tx_d    = {rd_byte[6:0], 1'b0};
              cnt_d   = 4'h1;
              if (blk_q) begin
                idx_d = idx_q + 7'h01;
              end
            end else begin
              state_d = cks_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_d = cks_pkg::ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      state_q   <= cks_pkg::ST_IDLE;
      stage_q   <= cks_pkg::STG_ADDR;
      cnt_q     <= 4'h0;
      sr_q      <= 8'h00;
      tx_q      <= 8'h00;
      oe_q      <= 1'b0;
      blk_q     <= 1'b0;
      idx_q     <= 7'h00;
      rd_mode_q <= 1'b0;
      mack_ok_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      stage_q   <= stage_d;
      cnt_q     <= cnt_d;
      sr_q      <= sr_d;
      tx_q      <= tx_d;
      oe_q      <= oe_d;
      blk_q     <= blk_d;
      idx_q     <= idx_d;
      rd_mode_q <= rd_mode_d;
      mack_ok_q <= mack_ok_d;
    end
  end

  // ---------------------------------------------------------------
  // link domain: config bytes
  // ---------------------------------------------------------------
  // a strap arrival wins over a serial write to bits 3:0 of the same byte
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cks_pkg::NUM_CFG; i++) begin
        cfg_q[i] <= cks_pkg::CFG_DEFAULTS[i*8 +: 8];
      end
    end else begin
      if (wr_en && in_range) begin
        cfg_q[idx_q[2:0]] <= sr_q;
      end
      if (strap_valid_l) begin
        cfg_q[cks_pkg::IDX_FSEL[2:0]][3:0] <= strap_data_l;
      end
    end
  end

  assign sw_load_l = wr_en & (idx_q == cks_pkg::IDX_FSEL) & ~strap_valid_l;
  assign sw_word_l = sr_q[cks_pkg::FSEL_LSB +: 4];
  assign sda_out   = 1'b0;
  assign sda_oe    = oe_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence seq_cmd_end;
    byte_end && stage_q == cks_pkg::STG_CMD;
  endsequence

  chk_strap_capture: assert property (@(posedge clock) disable iff (rst)
    (!latched_q && !pwrgd_s) |=> latched_q && strap_q == $past(straps_s))
    else $error("straps not captured on first strobe low");
  chk_strap_hold: assert property (@(posedge clock) disable iff (rst)
    (latched_q && !test_s) |=> $stable(strap_q) && latched_q)
    else $error("straps changed after one-shot capture");
  chk_pd_follow: assert property (@(posedge clock) disable iff (rst)
    (latched_q && pwrgd_s) |=> power_down_req)
    else $error("power-down request not raised");
  chk_link_rate: assert property (@(posedge clock) disable iff (rst)
    sel_q[3] |=> freq.link_khz == cks_pkg::KHZ_133 &&
                 freq.src_khz == cks_pkg::KHZ_100)
    else $error("link or src frequency wrong");
  chk_sw_mirror: assert property (@(posedge clock) disable iff (rst)
    (sw_valid && !cap) |=> sel_q == $past(sw_data))
    else $error("software select not applied");
  chk_addr_nack: assert property (@(posedge link_clk) disable iff (rst)
    (byte_end && stage_q == cks_pkg::STG_ADDR && !addr_hit)
      |=> !sda_oe && state_q == cks_pkg::ST_IDLE)
    else $error("foreign address was acknowledged");
  chk_addr_ack: assert property (@(posedge link_clk) disable iff (rst)
    (byte_end && stage_q == cks_pkg::STG_ADDR && addr_hit)
      |=> sda_oe && state_q == cks_pkg::ST_ACK)
    else $error("own address not acknowledged");
  chk_cmd_decode: assert property (@(posedge link_clk) disable iff (rst)
    seq_cmd_end |=> blk_q == !$past(sr_q[7]))
    else $error("command mode bit misdecoded");
  chk_idx_zero: assert property (@(posedge link_clk) disable iff (rst)
    (seq_cmd_end and cmd_blk) |=> idx_q == 7'h00)
    else $error("block index not zeroed");
  chk_count_skip: assert property (@(posedge link_clk) disable iff (rst)
    (seq_cmd_end and (cmd_blk && ser_en)) |=> stage_q == cks_pkg::STG_DATA)
    else $error("count phase not skipped");
  chk_blk_advance: assert property (@(posedge link_clk) disable iff (rst)
    (byte_end && stage_q == cks_pkg::STG_DATA && blk_q)
      |=> idx_q == $past(idx_q) + 7'h01)
    else $error("block index did not advance");
  chk_ack_release: assert property (@(posedge link_clk) disable iff (rst)
    (state_q == cks_pkg::ST_ACK && scl_fall && !rd_mode_q && !start_det)
      |=> !sda_oe && state_q == cks_pkg::ST_RX)
    else $error("ack not released after one bit");
endmodule
`default_nettype wire

// [verification/cks_smb_master.sv]
// two-wire controller model that drives the config link
`timescale 1ns/1ps
`default_nettype none
module cks_smb_master (
  input  wire logic link_clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  // ---------------------------------------------------------------
  // bit and byte level
  // ---------------------------------------------------------------
  // extra link clocks per scl phase; stretches a slow controller
  int stretch = 0;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // sda only moves while scl is low; phases stay >= 3 link clocks
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_drv <= b;
    wt(4 + stretch);
    scl <= 1'b1;
    wt(3);
    r = sda_wire;
    wt(3 + stretch);
    scl <= 1'b0;
  endtask

  task automatic start;
    wt(2);
    sda_drv <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(3);
    sda_drv <= 1'b0;
    wt(3);
    scl <= 1'b0;
  endtask

  task automatic stop;
    wt(2);
    sda_drv <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(3);
    sda_drv <= 1'b1;
    wt(3);
  endtask

  // tx of ff releases the line so the slave can send
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// [verification/tb_clock_synth_smbus_slave_and_freq_strap.sv]
// self-checking bench for the strap latch and config slave
`timescale 1ns/1ps
`default_nettype none
module tb_clock_synth_smbus_slave_and_freq_strap;
  logic                  clock;
  logic                  rst;
  logic                  link_clk;
  logic                  strobe;
  logic [3:0]            straps;
  logic                  test_mode;
  logic                  m_scl;
  logic                  m_sda;
  logic                  sda_out;
  logic                  sda_oe;
  logic                  straps_latched;
  logic                  power_down_req;
  cks_pkg::cks_freq_type freq;
  logic [7:0]            cfg [9];
  logic [31:0]           seed;
  logic [3:0]            s;
  logic [7:0]            d;
  int                    bad_count;
  int                    tests_run;
  // pull-up line: low when either side pulls
  wire cks_pkg::cks_smb_in_type smb = '{m_scl,
    m_sda & (sda_oe ? sda_out : 1'b1)};

  cks_top DUT (.clock(clock), .rst(rst), .link_clk(link_clk),
    .cpu_supply_good_strobe(strobe), .host_freq_select_straps(straps),
    .test_mode(test_mode), .smb_in(smb), .sda_out(sda_out),
    .sda_oe(sda_oe), .straps_latched(straps_latched),
    .power_down_req(power_down_req), .freq(freq));
  cks_smb_master M (.link_clk(link_clk), .sda_wire(smb.sda),
    .scl(m_scl), .sda_drv(m_sda));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic cks_pkg::cks_freq_type exp_freq(input logic [3:0] k);
    logic [19:0] c;
    case (k[2:0])
      3'h0: c = cks_pkg::KHZ_266;
      3'h1: c = cks_pkg::KHZ_133;
      3'h3: c = cks_pkg::KHZ_166;
      3'h4: c = cks_pkg::KHZ_333;
      3'h5: c = cks_pkg::KHZ_100;
      3'h6: c = cks_pkg::KHZ_400;
      default: c = cks_pkg::KHZ_200;
    endcase
    return '{c, (k[2:0] == 3'h7) ? cks_pkg::KHZ_250 : c, cks_pkg::KHZ_100,
             k[3] ? cks_pkg::KHZ_133 : cks_pkg::KHZ_066, cks_pkg::KHZ_033};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic ea);
    logic [7:0] rx;
    logic       a;
    M.xfer(b, 1'b1, rx, a);
    chk(a === ea, "ack");
  endtask

  task automatic get(input logic [7:0] e, input logic last);
    logic [7:0] rx;
    logic       a;
    M.xfer(8'hff, last, rx, a);
    chk(rx === e, "read data");
  endtask

  task automatic head(input logic [7:0] cmd);
    M.start();
    put(8'hd2, 1'b1);
    put(cmd, 1'b1);
  endtask

  task automatic rd1(input logic [6:0] i);
    head({1'b1, i});
    M.start();
    put(8'hd3, 1'b1);
    get(cfg[i], 1'b1);
    M.stop();
  endtask

  task automatic wr1(input logic [6:0] i, input logic [7:0] v);
    head({1'b1, i});
    put(v, 1'b1);
    M.stop();
    cfg[i] = v;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clocks and watchdog
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  // run needs about 1.6 ms; this leaves ample margin
  initial begin
    #3000000;
    bad_count++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    strobe = 1'b1;
    straps = 4'h0;
    test_mode = 1'b0;
    bad_count = 0;
    tests_run = 0;
    seed = 32'h8b22f39b;
    cfg = '{8'hff, 8'hff, 8'hff, 8'hf6, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    chk(freq === exp_freq(4'h0), "reset freq");
    chk(straps_latched === 1'b0, "reset latch");
    seed = lfsr(seed);
    s = seed[3:0];
    straps <= s;
    cyc(4);
    strobe <= 1'b0;
    cyc(6);
    chk(straps_latched === 1'b1, "latch");
    chk(freq === exp_freq(s), "strap freq");
    straps <= ~s;
    strobe <= 1'b1;
    cyc(6);
    chk(power_down_req === 1'b1, "pd high");
    strobe <= 1'b0;
    cyc(6);
    chk(power_down_req === 1'b0, "pd low");
    chk(freq === exp_freq(s), "one shot");
    test_mode <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      straps <= 4'(k);
      cyc(6);
      chk(freq === exp_freq(4'(k)), "code");
    end
    test_mode <= 1'b0;
    cyc(4);
    straps <= 4'h3;
    cyc(6);
    chk(freq === exp_freq(4'hf), "test exit");
    $display("strap test done");
    seed = lfsr(seed);
    d = seed[7:0];
    wr1(7'h04, d);
    cyc(8);
    chk(freq === exp_freq(d[3:0]), "sw select");
    for (int i = 0; i < 9; i++) rd1(7'(i));
    $display("byte test done");
    M.start();
    put(8'hd4, 1'b0);
    put(8'h84, 1'b0);
    M.stop();
    rd1(7'h04);
    $display("address test done");
    head(8'h00);
    put(cks_pkg::BLK_COUNT, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      cfg[i] = seed[7:0];
      put(cfg[i], 1'b1);
    end
    M.stop();
    M.stretch = 3;
    head(8'h00);
    M.start();
    put(8'hd3, 1'b1);
    get(cks_pkg::BLK_COUNT, 1'b0);
    for (int i = 0; i < 8; i++) get(cfg[i], i == 7);
    M.stop();
    M.stretch = 0;
    $display("block test done");
    wr1(7'h06, 8'h01);
    head(8'h00);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      cfg[i] = seed[7:0];
      put(cfg[i], 1'b1);
    end
    M.stop();
    for (int i = 0; i < 2; i++) rd1(7'(i));
    $display("count skip test done");
    end_sim();
  end
endmodule
`default_nettype wire
